// ### logic/psrcr_top.sv
// Configuration register access logic of a 16-bit pseudo-static RAM
//
// Overview of operation
// - Select input high sends any read or write cycle to configuration registers.
// - Select input low: every read or write cycle goes to the array, except the third and fourth operations of the top-address sequence.
// - Select-pin register write takes the new value from the address lines.
// - Async select-pin write captures at first rise of address-valid, CE or WE.
// - Address [19:18]: 10 bus config, 00 refresh config, 01 identification read.
// - Select-pin read ignores other address bits, drives 16 register bits.
// - Two reads then two writes at top address load a register.
// - Same pattern with a fourth read returns register contents.
// - Sequence targets the top word; that array word is left unchanged.
// - Third write data selects: 0 refresh, 1 bus config, 2 identification.
// - Fourth operation moves the selected register's 16 bits over data lines.
// - Both methods coexist in async mode; sequence works with the select input tied low.
// - Bus configuration register resets to its default value.
// - Bits [2:0] give burst length 4, 8, 16, 32 or continuous.
// - Bit 3 set: addresses increment linearly, not bounded by burst length.
// - Bit 3 clear: fixed bursts wrap modulo length inside aligned block.
// - Length and wrap apply equally to sync read and write bursts.
// - Identification register is read only; writes to it are ignored.
// - Variable latency: refresh during a read's latency count stalls the count and keeps wait asserted; refresh during data beats stalls nothing.
`timescale 1ns/100ps

module psrcr_top #(
    parameter logic [15:0] DEVICE_ID = 16'h0A5A // Arbitrary identification value
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire psrcr_pkg::psrcr_pins_t pins_i,
    input wire logic refresh_busy_i,
    input wire logic [15:0] arr_rdata_i,
    output logic [15:0] dq_o,
    output logic dq_oe_o,
    output logic wait_o,
    output logic arr_rd_o,
    output logic arr_wr_o,
    output logic [21:0] arr_addr_o,
    output logic [15:0] arr_wdata_o,
    output logic [1:0] arr_be_n_o,
    output logic [15:0] bus_configuration_o,
    output logic [15:0] refresh_configuration_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Register contents chosen by a pin-select code; reserved code reads zero
    function automatic logic [15:0] sel_read(input logic [1:0] sel, input logic [15:0] bus_configuration,
                                             input logic [15:0] refresh_configuration);
        logic [15:0] v;
        v = 16'h0000;
        if (sel == psrcr_pkg::SEL_BCR) begin
            v = bus_configuration;
        end else if (sel == psrcr_pkg::SEL_RCR) begin
            v = refresh_configuration;
        end else if (sel == psrcr_pkg::SEL_DID) begin
            v = DEVICE_ID;
        end
        return v;
    endfunction

    // Map a sequence data code onto the pin-select code space; 11 marks reserved
    function automatic logic [1:0] code_to_sel(input logic [15:0] code);
        logic [1:0] s;
        s = 2'h3;
        if (code == psrcr_pkg::SW_RCR) begin
            s = psrcr_pkg::SEL_RCR;
        end else if (code == psrcr_pkg::SW_BCR) begin
            s = psrcr_pkg::SEL_BCR;
        end else if (code == psrcr_pkg::SW_DID) begin
            s = psrcr_pkg::SEL_DID;
        end
        return s;
    endfunction

    // Next word address of a burst under the current length and wrap setting
    function automatic logic [21:0] burst_next(input logic [21:0] a, input logic [15:0] bus_configuration);
        logic [21:0] mask;
        logic [21:0] inc;
        mask = 22'h000000;
        inc = a + 22'h000001;
        case (bus_configuration[psrcr_pkg::BCR_LEN_LSB +: 3])
            psrcr_pkg::LEN_4: mask = 22'h000003;
            psrcr_pkg::LEN_8: mask = 22'h000007;
            psrcr_pkg::LEN_16: mask = 22'h00000F;
            psrcr_pkg::LEN_32: mask = 22'h00001F;
            default: mask = 22'h000000;
        endcase
        if (!bus_configuration[psrcr_pkg::BCR_WRAP_BIT] && mask != 22'h000000) begin
            return (a & ~mask) | (inc & mask);
        end
        return inc;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    psrcr_pkg::psrcr_pins_t prev_r;
    logic [15:0] bcr_r, bcr_nxt;
    logic [15:0] rcr_r, rcr_nxt;
    psrcr_pkg::psrcr_seq_t seq_r, seq_nxt;
    logic [1:0] seq_sel_r, seq_sel_nxt;
    logic op_wr_r, op_wr_nxt;
    logic op_done_r, op_done_nxt;
    logic sb_act_r, sb_act_nxt;
    logic sb_wr_r, sb_wr_nxt;
    logic sb_cfg_r, sb_cfg_nxt;
    logic [1:0] sb_sel_r, sb_sel_nxt;
    logic [2:0] lat_r, lat_nxt;
    logic [21:0] baddr_r, baddr_nxt;
    logic [15:0] dq_nxt;
    logic dq_oe_nxt, wait_nxt, arr_rd_nxt, arr_wr_nxt;
    logic [21:0] arr_addr_nxt;
    logic [15:0] arr_wdata_nxt;
    logic [1:0] arr_be_n_nxt;

    logic sync_mode;
    logic ce_rise, we_rise, adv_rise, byte_rise;
    logic cfg_edge, arr_edge;
    logic prev_top, cur_top, seq_hit;

    // Edges seen between the previous and the present sample of the pins
    assign sync_mode = !bcr_r[psrcr_pkg::BCR_MODE_BIT];
    assign ce_rise = !prev_r.ce_n && pins_i.ce_n;
    assign we_rise = !prev_r.we_n && pins_i.we_n;
    assign adv_rise = !prev_r.address_valid_n && pins_i.address_valid_n;
    assign byte_rise = (!prev_r.lower_byte_enable_n && pins_i.lower_byte_enable_n)
                     || (!prev_r.upper_byte_enable_n && pins_i.upper_byte_enable_n);
    // Byte enables play no part in a register write edge
    assign cfg_edge = op_wr_r && !op_done_r && (adv_rise || ce_rise || we_rise);
    assign arr_edge = op_wr_r && !op_done_r && (ce_rise || we_rise || byte_rise);
    assign prev_top = prev_r.addr == psrcr_pkg::TOP_ADDR;
    assign cur_top = pins_i.addr == psrcr_pkg::TOP_ADDR;
    assign seq_hit = seq_r == psrcr_pkg::SEQ_WR3 && cur_top && !pins_i.cfg_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic for registers, sequence tracker, bursts and outputs

    always_comb begin
        bcr_nxt = bcr_r;
        rcr_nxt = rcr_r;
        seq_nxt = seq_r;
        seq_sel_nxt = seq_sel_r;
        op_wr_nxt = op_wr_r;
        op_done_nxt = op_done_r;
        sb_act_nxt = sb_act_r;
        sb_wr_nxt = sb_wr_r;
        sb_cfg_nxt = sb_cfg_r;
        sb_sel_nxt = sb_sel_r;
        lat_nxt = lat_r;
        baddr_nxt = baddr_r;
        arr_rd_nxt = 1'b0;
        arr_wr_nxt = 1'b0;
        arr_addr_nxt = arr_addr_o;
        arr_wdata_nxt = arr_wdata_o;
        arr_be_n_nxt = arr_be_n_o;
        dq_nxt = dq_o;
        dq_oe_nxt = 1'b0;
        wait_nxt = !bcr_r[psrcr_pkg::BCR_WPOL_BIT];
        if (!sync_mode) begin
            // Asynchronous cycles: an operation lasts while chip enable is low
            if (!pins_i.ce_n && !pins_i.we_n) begin
                op_wr_nxt = 1'b1;
            end
            if (pins_i.ce_n) begin
                op_done_nxt = 1'b0;
                op_wr_nxt = 1'b0;
            end
            if (prev_r.cfg_sel && cfg_edge) begin
                op_done_nxt = 1'b1;
                // Register value comes from the address lines, not DQ
                if (prev_r.addr[psrcr_pkg::SEL_LSB +: 2] == psrcr_pkg::SEL_BCR) begin
                    bcr_nxt = prev_r.addr[15:0];
                end else if (prev_r.addr[psrcr_pkg::SEL_LSB +: 2] == psrcr_pkg::SEL_RCR) begin
                    rcr_nxt = prev_r.addr[15:0];
                end // Identification and reserved selections are dropped
            end else if (!prev_r.cfg_sel && arr_edge) begin
                op_done_nxt = 1'b1;
                if (prev_top && seq_r == psrcr_pkg::SEQ_RD2) begin
                    seq_sel_nxt = code_to_sel(prev_r.dq);
                    seq_nxt = psrcr_pkg::SEQ_WR3;
                end else if (prev_top && seq_r == psrcr_pkg::SEQ_WR3) begin
                    if (seq_sel_r == psrcr_pkg::SEL_BCR) begin
                        bcr_nxt = prev_r.dq;
                    end else if (seq_sel_r == psrcr_pkg::SEL_RCR) begin
                        rcr_nxt = prev_r.dq;
                    end
                    seq_nxt = psrcr_pkg::SEQ_IDLE;
                end else begin
                    arr_wr_nxt = 1'b1;
                    arr_addr_nxt = prev_r.addr;
                    arr_wdata_nxt = prev_r.dq;
                    arr_be_n_nxt = {prev_r.upper_byte_enable_n, prev_r.lower_byte_enable_n};
                    seq_nxt = psrcr_pkg::SEQ_IDLE;
                end
            end
            // A read ends at chip enable rising; count reads of the top word
            if (ce_rise && !op_wr_r && !prev_r.cfg_sel) begin
                if (!prev_top) begin
                    seq_nxt = psrcr_pkg::SEQ_IDLE;
                end else if (seq_r == psrcr_pkg::SEQ_IDLE) begin
                    seq_nxt = psrcr_pkg::SEQ_RD1;
                end else if (seq_r == psrcr_pkg::SEQ_RD1) begin
                    seq_nxt = psrcr_pkg::SEQ_RD2;
                end else if (seq_r == psrcr_pkg::SEQ_WR3) begin
                    seq_nxt = psrcr_pkg::SEQ_IDLE;
                end
            end
            // Read data path
            if (!pins_i.ce_n && pins_i.we_n) begin
                dq_oe_nxt = !pins_i.oe_n
                          && !(pins_i.lower_byte_enable_n && pins_i.upper_byte_enable_n);
                if (pins_i.cfg_sel) begin
                    dq_nxt = sel_read(pins_i.addr[psrcr_pkg::SEL_LSB +: 2], bcr_r, rcr_r);
                end else if (seq_hit) begin
                    dq_nxt = sel_read(seq_sel_r, bcr_r, rcr_r);
                end else begin
                    arr_rd_nxt = 1'b1;
                    arr_addr_nxt = pins_i.addr;
                    dq_nxt = arr_rdata_i;
                end
            end
        end else begin
            // Synchronous bursts start at chip enable and address-valid both low
            seq_nxt = psrcr_pkg::SEQ_IDLE;
            if (pins_i.ce_n) begin
                sb_act_nxt = 1'b0;
            end else if (!pins_i.address_valid_n) begin
                sb_act_nxt = 1'b1;
                sb_wr_nxt = !pins_i.we_n;
                sb_cfg_nxt = pins_i.cfg_sel;
                sb_sel_nxt = pins_i.addr[psrcr_pkg::SEL_LSB +: 2];
                lat_nxt = bcr_r[psrcr_pkg::BCR_LAT_LSB +: 3];
                baddr_nxt = pins_i.addr;
                if (pins_i.cfg_sel && !pins_i.we_n) begin
                    if (pins_i.addr[psrcr_pkg::SEL_LSB +: 2] == psrcr_pkg::SEL_BCR) begin
                        bcr_nxt = pins_i.addr[15:0];
                    end else if (pins_i.addr[psrcr_pkg::SEL_LSB +: 2] == psrcr_pkg::SEL_RCR) begin
                        rcr_nxt = pins_i.addr[15:0];
                    end
                end
            end else if (sb_act_r) begin
                if (lat_r != 3'h0) begin
                    // Variable latency stalls the count while a read meets a refresh
                    if (!(refresh_busy_i && !sb_wr_r && !bcr_r[psrcr_pkg::BCR_FIX_BIT])) begin
                        lat_nxt = lat_r - 3'h1;
                    end
                    wait_nxt = bcr_r[psrcr_pkg::BCR_WPOL_BIT];
                end else begin
                    // Data beat: same address stepping for reads and writes
                    baddr_nxt = burst_next(baddr_r, bcr_r);
                    if (sb_cfg_r) begin
                        dq_nxt = sel_read(sb_sel_r, bcr_r, rcr_r);
                        dq_oe_nxt = !sb_wr_r && !pins_i.oe_n;
                    end else begin
                        arr_addr_nxt = baddr_r;
                        arr_rd_nxt = !sb_wr_r;
                        arr_wr_nxt = sb_wr_r;
                        arr_wdata_nxt = pins_i.dq;
                        arr_be_n_nxt = {pins_i.upper_byte_enable_n,
                                        pins_i.lower_byte_enable_n};
                        dq_nxt = arr_rdata_i;
                        dq_oe_nxt = !sb_wr_r && !pins_i.oe_n;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers; configuration defaults load at reset

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_r <= '{cfg_sel: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                        address_valid_n: 1'b1, lower_byte_enable_n: 1'b1,
                        upper_byte_enable_n: 1'b1, addr: 22'h000000, dq: 16'h0000};
            bcr_r <= psrcr_pkg::BCR_RESET;
            rcr_r <= psrcr_pkg::RCR_RESET;
            seq_r <= psrcr_pkg::SEQ_IDLE;
            seq_sel_r <= 2'h3;
            op_wr_r <= 1'b0;
            op_done_r <= 1'b0;
            sb_act_r <= 1'b0;
            sb_wr_r <= 1'b0;
            sb_cfg_r <= 1'b0;
            sb_sel_r <= 2'h0;
            lat_r <= 3'h0;
            baddr_r <= 22'h000000;
            dq_o <= 16'h0000;
            dq_oe_o <= 1'b0;
            wait_o <= 1'b0;
            arr_rd_o <= 1'b0;
            arr_wr_o <= 1'b0;
            arr_addr_o <= 22'h000000;
            arr_wdata_o <= 16'h0000;
            arr_be_n_o <= 2'h3;
        end else begin
            prev_r <= pins_i;
            bcr_r <= bcr_nxt;
            rcr_r <= rcr_nxt;
            seq_r <= seq_nxt;
            seq_sel_r <= seq_sel_nxt;
            op_wr_r <= op_wr_nxt;
            op_done_r <= op_done_nxt;
            sb_act_r <= sb_act_nxt;
            sb_wr_r <= sb_wr_nxt;
            sb_cfg_r <= sb_cfg_nxt;
            sb_sel_r <= sb_sel_nxt;
            lat_r <= lat_nxt;
            baddr_r <= baddr_nxt;
            dq_o <= dq_nxt;
            dq_oe_o <= dq_oe_nxt;
            wait_o <= wait_nxt;
            arr_rd_o <= arr_rd_nxt;
            arr_wr_o <= arr_wr_nxt;
            arr_addr_o <= arr_addr_nxt;
            arr_wdata_o <= arr_wdata_nxt;
            arr_be_n_o <= arr_be_n_nxt;
        end
    end

    // Current settings for the rest of the device
    assign bus_configuration_o = bcr_r;
    assign refresh_configuration_o = rcr_r;

endmodule

// ### logic/psrcr_pkg.sv
// Package of constants, types and field layout for the configuration register access block
package psrcr_pkg;

    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;

    // Highest word address, the only target of the software sequence
    localparam logic [21:0] TOP_ADDR = 22'h3FFFFF;

    // Target selection on address bits [19:18] in a select-pin access
    localparam int SEL_LSB = 18;
    localparam logic [1:0] SEL_RCR = 2'h0;
    localparam logic [1:0] SEL_DID = 2'h1;
    localparam logic [1:0] SEL_BCR = 2'h2;

    // Third-operation data codes of the software sequence
    localparam logic [15:0] SW_RCR = 16'h0000;
    localparam logic [15:0] SW_BCR = 16'h0001;
    localparam logic [15:0] SW_DID = 16'h0002;

    // Reset values
    localparam logic [15:0] BCR_RESET = 16'h9D1F;
    localparam logic [15:0] RCR_RESET = 16'h0010;

    // Bus configuration field positions
    localparam int BCR_LEN_LSB = 0;
    localparam int BCR_WRAP_BIT = 3;
    localparam int BCR_WPOL_BIT = 10;
    localparam int BCR_LAT_LSB = 11;
    localparam int BCR_FIX_BIT = 14;
    localparam int BCR_MODE_BIT = 15;

    // Burst length codes in bits [2:0]
    localparam logic [2:0] LEN_4 = 3'h1;
    localparam logic [2:0] LEN_8 = 3'h2;
    localparam logic [2:0] LEN_16 = 3'h3;
    localparam logic [2:0] LEN_32 = 3'h4;
    localparam logic [2:0] LEN_CONT = 3'h7;

    // Progress of the software register access sequence
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RD1 = 2'b01,
        SEQ_RD2 = 2'b10,
        SEQ_WR3 = 2'b11
    } psrcr_seq_t;

    // Pins driven by the memory controller, sampled on clk_i
    typedef struct packed {
        logic cfg_sel;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic address_valid_n;
        logic lower_byte_enable_n;
        logic upper_byte_enable_n;
        logic [21:0] addr;
        logic [15:0] dq;
    } psrcr_pins_t;

endpackage

// ### dv/psrcr_properties.sv
// Port-level assertions for the configuration register access block
`timescale 1ns/100ps
module psrcr_properties #(
    parameter logic [15:0] DEVICE_ID = 16'h0A5A // Arbitrary identification value
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire psrcr_pkg::psrcr_pins_t pins_i,
    input wire logic refresh_busy_i,
    input wire logic [15:0] arr_rdata_i,
    input wire logic [15:0] dq_o,
    input wire logic dq_oe_o,
    input wire logic wait_o,
    input wire logic arr_rd_o,
    input wire logic arr_wr_o,
    input wire logic [21:0] arr_addr_o,
    input wire logic [15:0] arr_wdata_o,
    input wire logic [1:0] arr_be_n_o,
    input wire logic [15:0] bus_configuration_o,
    input wire logic [15:0] refresh_configuration_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////
    // Burst beat of either direction; async flag from the mode bit
    wire logic beat = arr_rd_o | arr_wr_o;
    wire logic asy = bus_configuration_o[15];
    // Async write opening with CE, then the write-enable rise that latches it
    sequence s_wr(logic s);
        asy && $fell(pins_i.ce_n) && !pins_i.we_n && pins_i.cfg_sel == s ##1 pins_i.we_n;
    endsequence
    // Async register read with the lower byte lane enabled
    sequence s_rd(logic [1:0] t);
        asy && pins_i.cfg_sel && !pins_i.ce_n && pins_i.we_n && !pins_i.oe_n
            && !pins_i.lower_byte_enable_n && pins_i.addr[19:18] == t;
    endsequence
    property p_cfg_write;
        pins_i.addr[19:18] == 2'h2 ##0 s_wr(1'b1)
            |=> bus_configuration_o == $past(pins_i.addr[15:0], 2);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("bus config not from address");
    property p_id_ro;
        pins_i.addr[19:18] == 2'h1 ##0 s_wr(1'b1)
            |=> $stable(bus_configuration_o) && $stable(refresh_configuration_o);
    endproperty
    a_id_ro: assert property (p_id_ro) else $error("id write changed a register");
    property p_arr_write;
        pins_i.addr != psrcr_pkg::TOP_ADDR ##0 s_wr(1'b0)
            |=> arr_wr_o && arr_addr_o == $past(pins_i.addr, 2);
    endproperty
    a_arr_write: assert property (p_arr_write) else $error("array write missing");
    property p_cfg_quiet;
        pins_i.cfg_sel [*2] |=> !arr_wr_o;
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet) else $error("array write in config space");
    property p_idle_stable;
        pins_i.ce_n [*2] |=> $stable(bus_configuration_o);
    endproperty
    a_idle_stable: assert property (p_idle_stable) else $error("bus config changed idle");
    property p_rd_bcr;
        s_rd(2'h2) |=> dq_oe_o && dq_o == bus_configuration_o;
    endproperty
    a_rd_bcr: assert property (p_rd_bcr) else $error("bus config read wrong");
    property p_rd_id;
        s_rd(2'h1) |=> dq_oe_o && dq_o == DEVICE_ID;
    endproperty
    a_rd_id: assert property (p_rd_id) else $error("id read wrong");
    property p_collision;
        !asy && !bus_configuration_o[14] && wait_o == bus_configuration_o[10]
            && refresh_busy_i && !pins_i.ce_n && pins_i.we_n |=> !arr_rd_o;
    endproperty
    a_collision: assert property (p_collision) else $error("read beat during refresh");
    property p_linear;
        !asy && bus_configuration_o[3] && beat && $past(beat)
            |-> arr_addr_o == $past(arr_addr_o) + 22'h1;
    endproperty
    a_linear: assert property (p_linear) else $error("linear burst step wrong");
    property p_wrap4;
        !asy && !bus_configuration_o[3] && bus_configuration_o[2:0] == 3'h1 && beat && $past(beat)
            |-> arr_addr_o == {$past(arr_addr_o[21:2]), $past(arr_addr_o[1:0]) + 2'h1};
    endproperty
    a_wrap4: assert property (p_wrap4) else $error("wrapped burst step wrong");
    // Main scenarios reached
    c_cfg_write: cover property (s_wr(1'b1));
    c_beats: cover property (!asy && beat ##1 beat);
    c_collision: cover property (refresh_busy_i && !asy && !pins_i.ce_n);
endmodule

bind psrcr_top psrcr_properties #(.DEVICE_ID(DEVICE_ID)) u_props (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .pins_i(pins_i), .refresh_busy_i(refresh_busy_i),
    .arr_rdata_i(arr_rdata_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .wait_o(wait_o),
    .arr_rd_o(arr_rd_o), .arr_wr_o(arr_wr_o), .arr_addr_o(arr_addr_o),
    .arr_wdata_o(arr_wdata_o), .arr_be_n_o(arr_be_n_o),
    .bus_configuration_o(bus_configuration_o),
    .refresh_configuration_o(refresh_configuration_o));

// ### dv/psrcr_ctl_model.sv
// Memory controller model that drives the device pins
`timescale 1ns/100ps
module psrcr_ctl_model (
    input wire logic clk_i,
    output psrcr_pkg::psrcr_pins_t pins_o
);
    initial pins_o = {1'b0, 6'h3F, 22'h3FFFFF, 16'hFFFF};
    ////////////////////////////////////////
    // Standby between cycles; released lines show the inverse of the last value
    task automatic idle(input logic [21:0] a, input logic [15:0] d);
        pins_o = {1'b0, 6'h3F, ~a, ~d};
    endtask
    // Async cycle: two sampled cycles with CE low, write enable rises first
    task automatic op(input logic wr, input logic sel, input logic be, input logic [21:0] a,
                      input logic [15:0] d);
        @(negedge clk_i);
        pins_o = {sel, 1'b0, !wr, wr, 1'b0, be, be, a, d};
        @(negedge clk_i);
        pins_o.we_n = 1'b1;
        @(negedge clk_i);
        idle(a, d);
    endtask
    // Sync start: CE and address-valid low for one edge; CE then held by the caller
    task automatic burst(input logic wr, input logic sel, input logic [21:0] a,
                         input logic [15:0] d);
        @(negedge clk_i);
        pins_o = {sel, 1'b0, !wr, wr, 3'h0, a, d};
        @(negedge clk_i);
        pins_o.address_valid_n = 1'b1;
    endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the configuration register access block
`timescale 1ns/100ps
module tb_top;
    localparam logic [15:0] ID = 16'h0A5A; // Arbitrary identification value
    localparam logic [21:0] TOP = psrcr_pkg::TOP_ADDR;
    localparam logic [15:0] F_TOP = 16'h3C5A; // Array model word at the top address
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic refresh_busy_i = 1'b0;
    psrcr_pkg::psrcr_pins_t pins;
    logic [15:0] dq_o, arr_rdata_i, arr_wdata_o, bus_configuration, refresh_configuration;
    logic dq_oe_o, wait_o, arr_rd_o, arr_wr_o, oe_q;
    logic [21:0] arr_addr_o;
    logic [1:0] arr_be_n_o;
    logic [15:0] rd_q[$];
    logic [21:0] wr_q[$];
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    integer seed = 32'h8B15;
    always #2.5 clk_i = ~clk_i;
    // Array model answers combinationally from the address
    assign arr_rdata_i = arr_addr_o[15:0] ^ 16'hC3A5;
    psrcr_ctl_model ctl (.clk_i(clk_i), .pins_o(pins));
    psrcr_top #(.DEVICE_ID(ID)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .pins_i(pins),
        .refresh_busy_i(refresh_busy_i), .arr_rdata_i(arr_rdata_i), .dq_o(dq_o),
        .dq_oe_o(dq_oe_o), .wait_o(wait_o), .arr_rd_o(arr_rd_o), .arr_wr_o(arr_wr_o),
        .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o), .arr_be_n_o(arr_be_n_o),
        .bus_configuration_o(bus_configuration), .refresh_configuration_o(refresh_configuration));
    ////////////////////////////////////////
    task automatic check(input logic [21:0] seen, input logic [21:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        err_count += rd_q.size() + wr_q.size();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Watcher: each read word or beat takes the oldest note off its queue
    // Read word is taken as the enable drops: array data lands a cycle late
    always @(posedge clk_i) begin
        #1;
        if (dq_oe_o !== 1'b1 && oe_q === 1'b1 && bus_configuration[15] === 1'b1) begin
            if (rd_q.size() > 0) check(dq_o, rd_q.pop_front());
            else check(22'h3FFFFF, 22'h0);
        end
        oe_q = dq_oe_o;
        if (arr_wr_o === 1'b1 || (arr_rd_o === 1'b1 && bus_configuration[15] === 1'b0)) begin
            if (wr_q.size() > 0) check(arr_addr_o, wr_q.pop_front());
            else check(22'h3FFFFF, 22'h0);
        end
    end
    // Cycle ceiling cuts a hang short
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            end_sim();
        end
    end
    // Select-pin address: target in [19:18], value low, random elsewhere
    function automatic logic [21:0] ca(input logic [1:0] t, input logic [15:0] v);
        logic [31:0] r;
        r = $random(seed);
        ca = {r[21:20], t, r[17:16], v};
    endfunction
    task automatic rd(input logic sel, input logic [21:0] a, input logic [15:0] e);
        rd_q.push_back(e);
        ctl.op(1'b0, sel, 1'b0, a, 16'h0);
    endtask
    // Two top reads, a code write, then the transfer
    task automatic sw(input logic [15:0] code, input logic wr4, input logic [15:0] v);
        rd(1'b0, TOP, F_TOP);
        rd(1'b0, TOP, F_TOP);
        ctl.op(1'b1, 1'b0, 1'b0, TOP, code);
        if (wr4) ctl.op(1'b1, 1'b0, 1'b0, TOP, v);
        else rd(1'b0, TOP, v);
    endtask
    // Sync transfer: hold CE low until all noted beats are seen, at least 12 for registers
    task automatic burst(input logic wr, input logic sel, input logic [21:0] a);
        int n;
        ctl.burst(wr, sel, a, 16'($random(seed)));
        n = 0;
        while (n < 200 && (wr_q.size() > 0 || (sel && n < 12))) begin
            @(posedge clk_i);
            #2;
            n++;
        end
        @(negedge clk_i);
        ctl.idle(a, 16'h0);
    endtask
    ////////////////////////////////////////
    initial begin
        logic [15:0] v, r, m;
        logic [21:0] a;
        logic [2:0] code[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h7};
        int len[6] = '{4, 8, 16, 32, 4, 0};
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        arst_n_i = 1'b1;
        check(bus_configuration, 16'h9D1F);
        $display("test 1 done");
        // Select-pin access with byte lanes off, then every target and the reserved one
        v = {1'b1, 15'($random(seed))};
        r = $random(seed);
        ctl.op(1'b1, 1'b1, 1'b1, ca(2'h2, v), 16'h0);
        ctl.op(1'b1, 1'b1, 1'b0, ca(2'h0, r), 16'h0);
        ctl.op(1'b1, 1'b1, 1'b0, ca(2'h1, ~v), 16'h0);
        ctl.op(1'b1, 1'b1, 1'b0, ca(2'h3, ~v), 16'h0);
        rd(1'b1, ca(2'h2, ~v), v);
        rd(1'b1, ca(2'h0, ~v), r);
        rd(1'b1, ca(2'h1, ~v), ID);
        rd(1'b0, ca(2'h0, v), v ^ 16'hC3A5);
        $display("test 2 done");
        // Software sequence with select tied low, every code and a reserved one
        v = {1'b1, 15'($random(seed))};
        sw(psrcr_pkg::SW_BCR, 1'b1, v);
        sw(psrcr_pkg::SW_DID, 1'b1, ~ID);
        sw(16'h0003, 1'b1, ~v);
        sw(16'h0003, 1'b0, 16'h0);
        sw(psrcr_pkg::SW_BCR, 1'b0, v);
        sw(psrcr_pkg::SW_RCR, 1'b0, r);
        sw(psrcr_pkg::SW_DID, 1'b0, ID);
        $display("test 3 done");
        // Broken sequence: its writes become ordinary array writes
        a = {6'h00, 16'($random(seed))};
        rd(1'b0, TOP, F_TOP);
        wr_q.push_back(a);
        ctl.op(1'b1, 1'b0, 1'b0, a, 16'h0001);
        wr_q.push_back(TOP);
        ctl.op(1'b1, 1'b0, 1'b0, TOP, psrcr_pkg::SW_BCR);
        wr_q.push_back(TOP);
        ctl.op(1'b1, 1'b0, 1'b0, TOP, ~v);
        rd(1'b1, ca(2'h2, 16'h0), v);
        $display("test 4 done");
        // Sync bursts over every length code, wrap and linear, reads and writes
        ctl.op(1'b1, 1'b1, 1'b0, ca(2'h2, 16'h1511), 16'h0);
        for (int i = 0; i < 6; i++) begin
            burst(1'b1, 1'b1, ca(2'h2, {8'h15, 4'h1, i > 3, code[i]}));
            a = $random(seed);
            m = (i > 3) ? 16'hFFFF : 16'(len[i] - 1);
            for (int k = 0; k < ((len[i] == 0) ? 6 : len[i] + 2); k++)
                wr_q.push_back(i > 3 ? a + 22'(k)
                    : {a[21:16], (a[15:0] & ~m) | ((a[15:0] + 16'(k)) & m)});
            if (i == 0) begin
                refresh_busy_i = 1'b1;
                fork
                    begin
                        repeat (6) @(negedge clk_i);
                        refresh_busy_i = 1'b0;
                    end
                join_none
            end
            burst(i[0], 1'b0, a);
        end
        $display("test 5 done");
        end_sim();
    end
endmodule
